// ### src/temp_indexed_calibration_loader.sv
// Calibration register loader with temperature-indexed lookup tables
// Assumes a byte-wide memory with one-request answers, an AXI4-Lite master
// on the same clock, and an 8-bit temperature code refreshed by the converter
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
module temp_indexed_calibration_loader #(
  parameter int REFRESH_CYCLES = `REFRESH_CYCLES,
  parameter int GAIN_W         = 4
) (
  // Clock, reset, enable
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    clk_en,
  // Override pin and temperature code
  input  wire logic                    unlock_pin,
  input  wire logic [7:0]              temp_code,
  output logic                         index_sample,
  // Byte memory port
  output cal_loader_pkg::nvm_req_t     nvm_req,
  input  cal_loader_pkg::nvm_rsp_t     nvm_rsp,
  // Calibration outputs
  output cal_loader_pkg::calibration_regs_t cal_out,
  output logic [GAIN_W-1:0]            coarse_gain,
  // AXI4-Lite write address and data
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [11:0]             s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp
);
  import cal_loader_pkg::*;

  initial begin
    if (REFRESH_CYCLES < 2) $error("REFRESH_CYCLES too small");
    if (GAIN_W < 1 || GAIN_W > 16) $error("GAIN_W out of range");
  end

  localparam int TW = $clog2(REFRESH_CYCLES + 1);

  // Clamp an index into the table range without wrap
  function automatic logic [7:0] clamp_index(input logic [7:0] idx);
    clamp_index = (idx > `INDEX_MAX) ? `INDEX_MAX : idx;
  endfunction : clamp_index

  // Word offset to byte address
  function automatic logic [`NVM_ADDR_W-1:0] word_addr(input logic [7:0] idx);
    word_addr = {1'b0, idx, 1'b0};
  endfunction : word_addr

  // Override pin synchroniser
  logic unlock_meta, unlock_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_meta <= 1'b0;
      unlock_sync <= 1'b0;
    end else if (clk_en) begin
      unlock_meta <= unlock_pin;
      unlock_sync <= unlock_meta;
    end
  end

  // Temperature code synchroniser
  logic [7:0] temp_meta, temp_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_meta <= 8'h00;
      temp_sync <= 8'h00;
    end else if (clk_en) begin
      temp_meta <= temp_code;
      temp_sync <= temp_meta;
    end
  end

  // State of loader and registers
  load_state_t             state, next_state;
  logic [TW-1:0]           timer, next_timer;
  logic [7:0]              temp_index, next_temp_index;
  logic [7:0]              write_protect_byte, next_write_protect_byte;
  logic                    loaded, next_loaded;
  logic                    tick;
  calibration_regs_t       calibration_regs, next_calibration_regs;
  logic                    rd_start;
  logic [`NVM_ADDR_W-1:0]  rd_addr;
  logic                    rd_done;
  logic [15:0]             rd_data;
  logic                    protected_mode;
  logic                    sw_load;
  logic                    wr_fire;
  logic [11:0]             wr_addr;
  logic [31:0]             wr_data;

  // Protected only with locked byte and override low
  assign protected_mode = (write_protect_byte == `PROTECT_LOCKED) && !unlock_sync;

  // 1 ms timer and index capture
  assign tick = (timer == TW'(REFRESH_CYCLES - 1));
  always_comb begin
    next_timer      = tick ? '0 : timer + TW'(1);
    next_temp_index = tick ? temp_sync : temp_index;
  end

  // Span table address with split layout
  function automatic logic [`NVM_ADDR_W-1:0] span_addr(input logic [7:0] idx);
    logic [7:0] c;
    c = clamp_index(idx);
    if (c < `SPAN_SPLIT_INDEX)
      span_addr = `SPAN_LOW_BASE + word_addr(c);
    else
      span_addr = `SPAN_HIGH_BASE + word_addr(c - `SPAN_SPLIT_INDEX);
  endfunction : span_addr

  // Load sequencer
  always_comb begin
    next_state              = state;
    next_loaded             = loaded;
    next_write_protect_byte = write_protect_byte;
    next_calibration_regs   = calibration_regs;
    rd_start                = 1'b0;
    rd_addr                 = `PROTECT_ADDR;
    case (state)
      ST_IDLE: begin
        if (!loaded || (tick && protected_mode) || sw_load)
          next_state = ST_PROTECT;
      end
      ST_PROTECT: begin
        rd_start = 1'b1;
        rd_addr  = `PROTECT_ADDR;
        if (rd_done) begin
          next_write_protect_byte = rd_data[15:8];
          next_state = (rd_data[15:8] == `PROTECT_LOCKED && !unlock_sync)
                       ? ST_SETUP : ST_DONE;
        end
      end
      ST_SETUP: begin
        rd_start = 1'b1;
        rd_addr  = `SETUP_ADDR;
        if (rd_done) begin
          next_calibration_regs.setup = rd_data;
          next_state = ST_OFS_TC;
        end
      end
      ST_OFS_TC: begin
        rd_start = 1'b1;
        rd_addr  = `OFFSET_TC_ADDR;
        if (rd_done) begin
          next_calibration_regs.offset_tempco_reg = rd_data;
          next_state = ST_SPAN_TC;
        end
      end
      ST_SPAN_TC: begin
        rd_start = 1'b1;
        rd_addr  = `SPAN_TC_ADDR;
        if (rd_done) begin
          next_calibration_regs.span_tempco_reg = rd_data;
          next_state = ST_OFS_DAC;
        end
      end
      ST_OFS_DAC: begin
        rd_start = 1'b1;
        rd_addr  = `OFFSET_TBL_BASE + word_addr(clamp_index(temp_index));
        if (rd_done) begin
          next_calibration_regs.offset_dac_reg = rd_data;
          next_state = ST_SPAN_DAC;
        end
      end
      ST_SPAN_DAC: begin
        rd_start = 1'b1;
        rd_addr  = span_addr(temp_index);
        if (rd_done) begin
          next_calibration_regs.span_dac_reg = rd_data;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_loaded = 1'b1;
        next_state  = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // Host writes land only when unprotected
    if (wr_fire && !protected_mode) begin
      case (wr_addr)
        `OFS_SETUP:         next_calibration_regs.setup             = wr_data[15:0];
        `OFS_OFFSET_DAC:    next_calibration_regs.offset_dac_reg    = wr_data[15:0];
        `OFS_SPAN_DAC:      next_calibration_regs.span_dac_reg      = wr_data[15:0];
        `OFS_OFFSET_TEMPCO: next_calibration_regs.offset_tempco_reg = wr_data[15:0];
        `OFS_SPAN_TEMPCO:   next_calibration_regs.span_tempco_reg   = wr_data[15:0];
        default: ;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state              <= ST_IDLE;
      timer              <= '0;
      temp_index         <= `INDEX_MIN;
      write_protect_byte <= `PROTECT_OPEN;
      loaded             <= 1'b0;
      calibration_regs   <= {5{`CAL_RESET}};
    end else if (clk_en) begin
      state              <= next_state;
      timer              <= next_timer;
      temp_index         <= next_temp_index;
      write_protect_byte <= next_write_protect_byte;
      loaded             <= next_loaded;
      calibration_regs   <= next_calibration_regs;
    end
  end

  // Word reader; start pulses once per state entry
  logic rd_pending;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_pending <= 1'b0;
    else if (clk_en) rd_pending <= rd_start && !rd_done;
  end

  nvm_word_reader u_reader (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clk_en    (clk_en),
    .start     (rd_start && !rd_pending),
    .base_addr (rd_addr),
    .word_done (rd_done),
    .word_data (rd_data),
    .nvm_req   (nvm_req),
    .nvm_rsp   (nvm_rsp)
  );

  // Outputs: coarse gain from setup, span DAC applied separately
  assign cal_out      = calibration_regs;
  assign coarse_gain  = calibration_regs.setup[GAIN_W-1:0];
  assign index_sample = tick;

  // AXI4-Lite write channel state
  logic aw_held, next_aw_held, w_held, next_w_held, bvalid, next_bvalid;
  logic [11:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [1:0]  bresp_q, next_bresp_q;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign wr_fire = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held  || (s_axi_wvalid  && s_axi_wready)) && !bvalid;
  assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held  ? wdata_q  : s_axi_wdata;
  assign sw_load = wr_fire && wr_addr == `OFS_CONTROL && wr_data[`CTL_LOAD_BIT];

  // Write handshake, either order
  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q  = wdata_q;
    next_bvalid   = bvalid;
    next_bresp_q  = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held  = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_wdata_q = s_axi_wdata;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp_q = (wr_addr[1:0] != 2'b00 || wr_addr > `OFS_TEMP_INDEX)
                     ? 2'b10 : 2'b00;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Read channel
  logic rvalid, next_rvalid;
  logic [31:0] rdata_q, next_rdata_q;
  logic [1:0]  rresp_q, next_rresp_q;
  assign s_axi_arready = !rvalid;

  always_comb begin
    next_rvalid  = rvalid;
    next_rdata_q = rdata_q;
    next_rresp_q = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid  = 1'b1;
      next_rresp_q = 2'b00;
      case (s_axi_araddr)
        `OFS_SETUP:         next_rdata_q = {16'h0000, calibration_regs.setup};
        `OFS_OFFSET_DAC:    next_rdata_q = {16'h0000, calibration_regs.offset_dac_reg};
        `OFS_SPAN_DAC:      next_rdata_q = {16'h0000, calibration_regs.span_dac_reg};
        `OFS_OFFSET_TEMPCO: next_rdata_q = {16'h0000, calibration_regs.offset_tempco_reg};
        `OFS_SPAN_TEMPCO:   next_rdata_q = {16'h0000, calibration_regs.span_tempco_reg};
        `OFS_STATUS:        next_rdata_q = {29'h0000_0000, loaded, state != ST_IDLE,
                                            protected_mode};
        `OFS_CONTROL:       next_rdata_q = 32'h0000_0000;
        `OFS_TEMP_INDEX:    next_rdata_q = {24'h00_0000, temp_index};
        default: begin
          next_rdata_q = 32'h0000_0000;
          next_rresp_q = 2'b10;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      bvalid   <= 1'b0;
      bresp_q  <= 2'b00;
      rvalid   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end else if (clk_en) begin
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q  <= next_wdata_q;
      bvalid   <= next_bvalid;
      bresp_q  <= next_bresp_q;
      rvalid   <= next_rvalid;
      rdata_q  <= next_rdata_q;
      rresp_q  <= next_rresp_q;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : temp_indexed_calibration_loader

// ### src/cal_loader_cfg.svh
// Constants for the calibration loader: addresses, timings, reset values
// Assumes inclusion by bare name from the package and testbench files
`ifndef CAL_LOADER_CFG_SVH
`define CAL_LOADER_CFG_SVH

// Register offsets on the AXI4-Lite bus
`define OFS_SETUP         12'h000
`define OFS_OFFSET_DAC    12'h004
`define OFS_SPAN_DAC      12'h008
`define OFS_OFFSET_TEMPCO 12'h00C
`define OFS_SPAN_TEMPCO   12'h010
`define OFS_STATUS        12'h014
`define OFS_CONTROL       12'h018
`define OFS_TEMP_INDEX    12'h01C

// Status and control field positions
`define ST_PROTECTED_BIT  0
`define ST_BUSY_BIT       1
`define ST_LOADED_BIT     2
`define CTL_LOAD_BIT      0

// Memory layout (byte addresses, high byte at the lower address)
`define NVM_ADDR_W        10
`define OFFSET_TBL_BASE   10'h000
`define OFFSET_TBL_LAST   10'h15F
`define SPAN_LOW_BASE     10'h200
`define SPAN_HIGH_BASE    10'h1A0
`define SPAN_SPLIT_INDEX  8'h80
`define SETUP_ADDR        10'h162
`define OFFSET_TC_ADDR    10'h166
`define SPAN_TC_ADDR      10'h168
`define PROTECT_ADDR      10'h16E

// Index limits and protect byte values
`define INDEX_MIN         8'h00
`define INDEX_MAX         8'hAF
`define PROTECT_LOCKED    8'hFF
`define PROTECT_OPEN      8'h00

// Refresh interval
`define REFRESH_US        1000
`define CLK_MHZ           50
`define REFRESH_CYCLES    (`REFRESH_US * `CLK_MHZ)

// Reset value of calibration registers
`define CAL_RESET         16'h0000

`endif

// ### src/cal_loader_pkg.sv
// Types shared by the calibration loader files
// Assumes the constants header is on the include path
`include "cal_loader_cfg.svh"
package cal_loader_pkg;

  // Load sequencer states, Gray coded along the load path
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_PROTECT  = 4'b0001,
    ST_SETUP    = 4'b0011,
    ST_OFS_TC   = 4'b0010,
    ST_SPAN_TC  = 4'b0110,
    ST_OFS_DAC  = 4'b0111,
    ST_SPAN_DAC = 4'b0101,
    ST_DONE     = 4'b0100
  } load_state_t;

  // The five calibration registers
  typedef struct packed {
    logic [15:0] setup;
    logic [15:0] offset_dac_reg;
    logic [15:0] span_dac_reg;
    logic [15:0] offset_tempco_reg;
    logic [15:0] span_tempco_reg;
  } calibration_regs_t;

  // Byte read request to memory
  typedef struct packed {
    logic                    valid;
    logic [`NVM_ADDR_W-1:0]  addr;
  } nvm_req_t;

  // Byte read answer from memory
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } nvm_rsp_t;

endpackage : cal_loader_pkg

// ### src/nvm_word_reader.sv
// Assembles one 16-bit word from two adjacent memory bytes
// Assumes a byte memory answering each request with a later valid
`timescale 1ns/1ps
module nvm_word_reader (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    clk_en,
  // Word request
  input  wire logic                    start,
  input  wire logic [`NVM_ADDR_W-1:0]  base_addr,
  output logic                         word_done,
  output logic [15:0]                  word_data,
  // Byte memory port
  output cal_loader_pkg::nvm_req_t     nvm_req,
  input  cal_loader_pkg::nvm_rsp_t     nvm_rsp
);
  import cal_loader_pkg::*;

  logic                    busy, next_busy;
  logic                    second, next_second;
  logic                    issue, next_issue;
  logic [`NVM_ADDR_W-1:0]  addr, next_addr;
  logic [15:0]             data, next_data;
  logic                    done, next_done;

  // Two byte fetches, high byte first
  always_comb begin
    next_busy   = busy;
    next_second = second;
    next_issue  = 1'b0;
    next_addr   = addr;
    next_data   = data;
    next_done   = 1'b0;
    if (!busy && start) begin
      next_busy   = 1'b1;
      next_second = 1'b0;
      next_issue  = 1'b1;
      next_addr   = base_addr;
    end else if (busy && nvm_rsp.valid) begin
      if (!second) begin
        next_data[15:8] = nvm_rsp.data;
        next_second     = 1'b1;
        next_issue      = 1'b1;
        next_addr       = addr + `NVM_ADDR_W'(1);
      end else begin
        next_data[7:0] = nvm_rsp.data;
        next_busy      = 1'b0;
        next_done      = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy   <= 1'b0;
      second <= 1'b0;
      issue  <= 1'b0;
      addr   <= '0;
      data   <= '0;
      done   <= 1'b0;
    end else if (clk_en) begin
      busy   <= next_busy;
      second <= next_second;
      issue  <= next_issue;
      addr   <= next_addr;
      data   <= next_data;
      done   <= next_done;
    end
  end

  assign nvm_req.valid = issue;
  assign nvm_req.addr  = addr;
  assign word_done     = done;
  assign word_data     = data;

endmodule : nvm_word_reader

// ### testbench/cal_loader_properties.sv
// Port assertions for the calibration loader
// Assumes binding into temp_indexed_calibration_loader, one clock domain
`timescale 1ns/1ps
`include "cal_loader_cfg.svh"
module cal_loader_properties
  import cal_loader_pkg::*;
#(
  parameter int REFRESH_CYCLES = 100,
  parameter int GAIN_W         = 4
) (
  // Clock, reset, tick
  input wire logic                              aclk,
  input wire logic                              aresetn,
  input wire logic                              clk_en,
  input wire logic                              index_sample,
  // Memory and outputs
  input cal_loader_pkg::nvm_req_t               nvm_req,
  input cal_loader_pkg::calibration_regs_t      cal_out,
  input wire logic [GAIN_W-1:0]                 coarse_gain,
  // Bus handshakes
  input wire logic                              s_axi_awvalid,
  input wire logic                              s_axi_awready,
  input wire logic                              s_axi_wvalid,
  input wire logic                              s_axi_wready,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready,
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_rready,
  input wire logic [31:0]                       s_axi_rdata
);
  int   gap;
  logic seen;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the previous refresh tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (clk_en) begin
      gap  <= index_sample ? 0 : gap + 1;
      seen <= seen | index_sample;
    end
  end

  tick_period_a: assert property (index_sample && seen |-> gap == REFRESH_CYCLES - 1)
    else $error("refresh tick spacing wrong");
  req_pulse_a: assert property (nvm_req.valid |=> !nvm_req.valid)
    else $error("memory request longer than one cycle");
  addr_range_a: assert property (nvm_req.valid |-> nvm_req.addr <= 10'h15F ||
    (nvm_req.addr >= 10'h162 && nvm_req.addr <= 10'h16F) ||
    (nvm_req.addr >= 10'h1A0 && nvm_req.addr <= 10'h2FF))
    else $error("memory address outside tables");
  gain_follow_a: assert property (coarse_gain == cal_out.setup[GAIN_W-1:0])
    else $error("coarse gain not taken from setup");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && !s_axi_awready)
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : cal_loader_properties

bind temp_indexed_calibration_loader cal_loader_properties #(
  .REFRESH_CYCLES(REFRESH_CYCLES),
  .GAIN_W(GAIN_W)
) u_props (
  .aclk, .aresetn, .clk_en, .index_sample, .nvm_req, .cal_out, .coarse_gain,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata
);

// ### testbench/nvm_byte_model.sv
// Byte-wide table memory answering the loader's read requests
// Assumes one request outstanding at a time on the loader's clock
`timescale 1ns/1ps
`include "cal_loader_cfg.svh"
module nvm_byte_model
  import cal_loader_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Answer speed and protect byte
  input  wire logic                 slow,
  input  wire logic [7:0]           protect_val,
  // Byte port
  input  cal_loader_pkg::nvm_req_t  nvm_req,
  output cal_loader_pkg::nvm_rsp_t  nvm_rsp
);
  logic [9:0] addr_q;
  int         wait_q;

  // Content follows the address, but words can repeat (0x000 and 0x140 match)
  function automatic logic [7:0] byte_at(input logic [9:0] a);
    if (a == `PROTECT_ADDR) return protect_val;
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : byte_at

  // One answer per request after one or three cycles; idle data toggles
  always @(posedge aclk) begin
    nvm_rsp.valid <= 1'b0;
    nvm_rsp.data  <= ~nvm_rsp.data;
    if (!aresetn) begin
      wait_q       <= 0;
      nvm_rsp.data <= 8'h5A;
    end else if (nvm_req.valid) begin
      addr_q <= nvm_req.addr;
      wait_q <= slow ? 3 : 1;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 1) begin
      wait_q        <= 0;
      nvm_rsp.valid <= 1'b1;
      nvm_rsp.data  <= byte_at(addr_q);
    end
  end
endmodule : nvm_byte_model

// ### testbench/temp_indexed_calibration_loader_tb.sv
// Self-checking bench for the calibration loader
// Assumes loader, package and memory model are compiled first
`timescale 1ns/1ps
`include "cal_loader_cfg.svh"
module temp_indexed_calibration_loader_tb;
  import cal_loader_pkg::*;
  logic              aclk, aresetn, clk_en, unlock_pin, index_sample, slow;
  logic [7:0]        temp_code, protect_val;
  nvm_req_t          nvm_req;
  nvm_rsp_t          nvm_rsp;
  calibration_regs_t cal_out;
  logic [3:0]        coarse_gain, wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [1:0]        bresp, rresp, r;
  int                errors, checks_done;

  temp_indexed_calibration_loader #(.REFRESH_CYCLES(100)) u_dut (
    .aclk, .aresetn, .clk_en, .unlock_pin, .temp_code, .index_sample, .nvm_req,
    .nvm_rsp, .cal_out, .coarse_gain, .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  nvm_byte_model u_mem (.aclk, .aresetn, .slow, .protect_val, .nvm_req, .nvm_rsp);

  // Clock at 50 MHz
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  function automatic logic [31:0] wd(input logic [9:0] a);
    return {16'h0000, u_mem.byte_at(a), u_mem.byte_at(a + 10'd1)};
  endfunction : wd

  // Bus write: aw and w offered together, each freed when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    rs = bresp;
    bready <= 1'b0;
    chk(bvalid, 1);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    {v, rs} = {rdata, rresp};
    rready <= 1'b0;
    chk(rvalid, 1);
  endtask : rd

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!index_sample && n < 300);
    chk(index_sample, 1);
  endtask : wait_tick

  task automatic wait_idle;
    int n;
    n = 0;
    d = 32'h2;
    repeat (3) @(posedge aclk);
    while (d[`ST_BUSY_BIT] !== 1'b0 && n < 200) begin
      rd(`OFS_STATUS, d, r);
      n++;
    end
    chk(d[`ST_BUSY_BIT], 0);
  endtask : wait_idle

  // Protected power-on load of all five registers, index still zero
  task automatic t_power_on;
    do_reset();
    wait_idle();
    chk(d[`ST_PROTECTED_BIT], 1);
    chk(cal_out.setup, wd(`SETUP_ADDR));
    chk(cal_out.offset_tempco_reg, wd(`OFFSET_TC_ADDR));
    chk(cal_out.span_tempco_reg, wd(`SPAN_TC_ADDR));
    chk(cal_out.offset_dac_reg, wd(`OFFSET_TBL_BASE));
    chk(cal_out.span_dac_reg, wd(`SPAN_LOW_BASE));
    $display("power_on done");
  endtask : t_power_on

  // Refresh at each tick with boundary indices and both memory speeds
  task automatic t_refresh;
    logic [7:0] ix [6] = '{8'h00, 8'h7F, 8'h80, 8'hAF, 8'hB0, 8'hFF};
    logic [7:0] c;
    for (int i = 0; i < 6; i++) begin
      wait_tick();
      temp_code <= ix[i];
      slow      <= i[0];
      wait_tick();
      wait_idle();
      c = (ix[i] > `INDEX_MAX) ? `INDEX_MAX : ix[i];
      chk(cal_out.offset_dac_reg, wd(10'({c, 1'b0})));
      rd(`OFS_SPAN_DAC, d, r);
      chk(d, wd(c < `SPAN_SPLIT_INDEX ? `SPAN_LOW_BASE + 10'({c, 1'b0}) :
        `SPAN_HIGH_BASE + 10'({c - `SPAN_SPLIT_INDEX, 1'b0})));
    end
    $display("refresh done");
  endtask : t_refresh

  // Host writes ignored while protected, taken with the override pin high
  task automatic t_override;
    wr(`OFS_OFFSET_TEMPCO, 32'h0000_1234, r);
    chk(r, 0);
    chk(cal_out.offset_tempco_reg, wd(`OFFSET_TC_ADDR));
    unlock_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_OFFSET_TEMPCO, i ? 32'h0000_FFFF : 32'h0000_0000, r);
      wr(`OFS_SPAN_TEMPCO, i ? 32'h0000_0000 : 32'h0000_FFFF, r);
      rd(`OFS_OFFSET_TEMPCO, d, r);
      chk(d, i ? 32'h0000_FFFF : 32'h0000_0000);
      chk(cal_out.span_tempco_reg, i ? 16'h0000 : 16'hFFFF);
    end
    wr(`OFS_SETUP, 32'h0000_0009, r);
    wait_tick();
    wait_tick();
    chk(coarse_gain, 4'h9);
    chk(cal_out.offset_tempco_reg, 16'hFFFF);
    unlock_pin <= 1'b0;
    $display("override done");
  endtask : t_override

  // Protect byte open: nothing loaded, writes stand across ticks
  task automatic t_open;
    protect_val <= `PROTECT_OPEN;
    do_reset();
    wait_idle();
    chk(d[`ST_PROTECTED_BIT], 0);
    chk(cal_out.setup, 0);
    wr(`OFS_OFFSET_DAC, 32'h0000_ABCD, r);
    wait_tick();
    wait_idle();
    chk(cal_out.offset_dac_reg, 16'hABCD);
    rd(12'h020, d, r);
    chk({d, r}, 34'h2);
    wr(12'h006, 32'h0000_0001, r);
    chk(r, 2'b10);
    $display("open done");
  endtask : t_open

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    {aresetn, unlock_pin, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
    clk_en      = 1'b1;
    wstrb       = 4'hF;
    temp_code   = 8'h00;
    protect_val = `PROTECT_LOCKED;
    {awaddr, araddr, wdata} = '0;
    {errors, checks_done} = '0;
    t_power_on();
    t_refresh();
    t_override();
    t_open();
    end_sim();
  end
endmodule : temp_indexed_calibration_loader_tb
